// ==== rtl/line_irq_defines.svh ====
`ifndef LINE_IRQ_DEFINES_SVH
`define LINE_IRQ_DEFINES_SVH

// register offsets on the serial control port
`define REG_CONTROL_TWO       6'h02
`define REG_INTERRUPT_MASK    6'h03
`define REG_IRQ_FLAGS         6'h04
`define REG_HOOK_CONTROL      6'h05

// control_two field positions
`define C2_IRQ_PIN_SELECT     7
`define C2_IRQ_POLARITY       6
`define C2_RESERVED           5
`define C2_WDOG_ON            4
`define C2_EXT_LOOPBACK_ON    3
`define C2_RING_BOTH_EDGES    2
`define C2_HYBRID_CONNECT     1
`define C2_RX_PATH_ON         0

// interrupt source / mask bit positions (same layout in both)
`define SRC_RING              7
`define SRC_RX_OVERLOAD       6
`define SRC_FRAME_LOSS        5
`define SRC_BILLING_TONE      4
`define SRC_SUPPLY_DROPOUT    3
`define SRC_LOOP_CURRENT_MAX  2
`define SRC_TIP_GROUND        1
`define SRC_POLARITY_FLIP     0

// hook control field position
`define HOOK_OFFHOOK_CTL      0

// reset values
`define CONTROL_TWO_RST       8'h00
`define INTERRUPT_MASK_RST    8'h00
`define IRQ_FLAGS_RST         8'h00
`define OFFHOOK_RST           1'b0

// serial frame layout: command byte then data byte
`define CMD_READ_BIT          7
`define CMD_ADDR_W            6
`define SPI_LAST_CMD_BIT      4'h7
`define SPI_LAST_DATA_BIT     4'hF

// line-side status width
`define LOOP_LEVEL_W          5

// timing
`define CLK_FREQ_KHZ          250000
`define WDOG_TIMEOUT_MS       4000
`define WDOG_CYCLES           (`WDOG_TIMEOUT_MS * `CLK_FREQ_KHZ)
`define WDOG_CNT_W            30

`endif

// ==== rtl/line_irq_pkg.sv ====
package line_irq_pkg;

  // serial port frame phase, one-hot
  typedef enum logic [2:0] {
    PH_IDLE = 3'b001,
    PH_CMD  = 3'b010,
    PH_DATA = 3'b100
  } spi_phase_t;

endpackage : line_irq_pkg

// ==== rtl/status_event_flag.sv ====
`timescale 1ns/10ps

// synchronises one line-side status, detects edges, holds a sticky flag
module status_event_flag #(
  parameter int W = 1
) (
  input  wire logic         clk_sys_i,
  input  wire logic         resetn_i,
  input  wire logic [W-1:0] sig_i,      // asynchronous status from line side
  input  wire logic         rise_en_i,  // flag on condition becoming true
  input  wire logic         fall_en_i,  // flag on condition becoming false
  input  wire logic         clr_i,      // software clear pulse
  output logic              flag_o,     // sticky flag
  output logic              level_o     // synchronised condition
);

  logic [W-1:0] sync_a_q;   // first stage, read only by second stage
  logic [W-1:0] sync_b_q;   // second stage
  logic         cond;       // condition: every bit of the status high
  logic         cond_q;     // condition one cycle ago
  logic         event_set;  // edge selected by the enables

  // two-flop synchroniser
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      sync_a_q <= '0;
      sync_b_q <= '0;
    end else begin
      sync_a_q <= sig_i;
      sync_b_q <= sync_a_q;
    end
  end

  // all-ones test on synced bits; bits may skew by a cycle, so a
  // multi-bit status can show a one-cycle late edge, or a false one from a mixed sample of old and new bits
  assign cond = &sync_b_q;

  // edge history
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      cond_q <= 1'b0;
    end else begin
      cond_q <= cond;
    end
  end

  assign event_set = (rise_en_i & cond & ~cond_q) | (fall_en_i & ~cond & cond_q);

  // sticky flag, a new event beats a clear in the same cycle
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      flag_o <= 1'b0;
    end else if (event_set) begin
      flag_o <= 1'b1;
    end else if (clr_i) begin
      flag_o <= 1'b0;
    end
  end

  assign level_o = cond_q;

endmodule : status_event_flag

// ==== rtl/line_interface_irq_control.sv ====
`timescale 1ns/10ps
`include "line_irq_defines.svh"

// Contract
// - bit 7 picks call-progress or interrupt pin
// - bit 6 sets interrupt pin active level
// - watchdog enable sticks until hardware reset
// - four seconds without access forces on-hook
// - every read or write restarts watchdog
// - timeout clears off-hook; write sets again
// - bit 3 drives external analog loopback
// - mode 0: ring interrupt at burst start
// - mode 1: ring interrupt start and end
// - end interrupt only if flag cleared
// - bit 1 connects hybrid in transmit
// - bit 0 enables receive path
// - mask 7 gates ring onto pin
// - mask 6 gates receive overload
// - mask 5 gates frame lock loss
// - mask 4 gates billing tone
// - mask 3 gates supply dropout
// - mask 2 gates loop current all ones
// - mask 1 gates tip ground going active
// - mask 0 gates line polarity flip
// - pin asserts: flag, mask, pin select
// - flags stay set until written zero
module line_interface_irq_control #(
  parameter int unsigned WDOG_CYCLES = `WDOG_CYCLES  // watchdog window in clocks
) (
  input  wire logic                     clk_sys_i,
  input  wire logic                     resetn_i,
  // serial control port
  input  wire logic                     spi_sclk_i,
  input  wire logic                     spi_cs_n_i,
  input  wire logic                     spi_sdi_i,
  output logic                          spi_sdo_o,
  output logic                          spi_sdo_oe_o,
  // line-side status, asynchronous
  input  wire logic                     ring_detect_i,
  input  wire logic                     rx_overload_i,
  input  wire logic                     frame_lock_lost_i,
  input  wire logic                     billing_tone_i,
  input  wire logic                     supply_dropout_i,
  input  wire logic [`LOOP_LEVEL_W-1:0] loop_current_level_i,
  input  wire logic                     tip_ground_status_i,
  input  wire logic                     line_voltage_msb_i,
  // call-progress stream from the audio path, same clock
  input  wire logic                     callprog_i,
  // shared pin and controls
  output logic                          callprog_or_irq_pin_o,
  output logic                          offhook_ctl_o,
  output logic                          ext_loopback_on_o,
  output logic                          hybrid_connect_o,
  output logic                          rx_path_on_o
);

  // ---------------------------------------------------------------
  // serial port pin synchronisers
  // ---------------------------------------------------------------
  logic [1:0] sclk_sync_q;  // [0] first stage, [1] second stage
  logic [1:0] cs_sync_q;    // chip select, active low
  logic [1:0] sdi_sync_q;   // serial data in
  logic       sclk_prev_q;  // previous synced clock for edge detect

  // two flops per pin before anything looks at it
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      sclk_sync_q <= 2'h0;
      cs_sync_q   <= 2'h3;
      sdi_sync_q  <= 2'h0;
    end else begin
      sclk_sync_q <= {sclk_sync_q[0], spi_sclk_i};
      cs_sync_q   <= {cs_sync_q[0], spi_cs_n_i};
      sdi_sync_q  <= {sdi_sync_q[0], spi_sdi_i};
    end
  end

  // clock edge history, reads only the second stage
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      sclk_prev_q <= 1'b0;
    end else begin
      sclk_prev_q <= sclk_sync_q[1];
    end
  end

  logic sel;        // frame in progress
  logic sclk_rise;  // master shifts data in on rising edge
  logic sclk_fall;  // we update sdo on falling edge

  assign sel       = ~cs_sync_q[1];
  assign sclk_rise = sel & sclk_sync_q[1] & ~sclk_prev_q;
  assign sclk_fall = sel & ~sclk_sync_q[1] & sclk_prev_q;

  // ---------------------------------------------------------------
  // serial frame decoder: command byte, then data byte
  // ---------------------------------------------------------------
  line_irq_pkg::spi_phase_t phase_q;  // frame phase
  logic [3:0]               bit_cnt_q;  // bits taken this frame
  logic [7:0]               shift_in_q; // incoming bits, msb first
  logic [7:0]               cmd_q;      // captured command byte
  logic [7:0]               shift_out_q;// read data still to send
  logic                     wr_pulse;   // register write, one cycle
  logic                     access_pulse; // any completed access
  logic [7:0]               wr_data;    // data byte of a write
  logic [`CMD_ADDR_W-1:0]   addr;       // addressed register
  logic                     is_read;    // command is a read
  logic [7:0]               rd_data;    // mux of readable registers

  assign addr    = cmd_q[`CMD_ADDR_W-1:0];
  assign is_read = cmd_q[`CMD_READ_BIT];
  assign wr_data = {shift_in_q[6:0], sdi_sync_q[1]};

  // phase sequencing and bit count
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      phase_q   <= line_irq_pkg::PH_IDLE;
      bit_cnt_q <= 4'h0;
    end else if (!sel) begin
      // deselect aborts any partial frame
      phase_q   <= line_irq_pkg::PH_IDLE;
      bit_cnt_q <= 4'h0;
    end else begin
      case (phase_q)
        line_irq_pkg::PH_IDLE: begin
          phase_q <= line_irq_pkg::PH_CMD;
        end
        line_irq_pkg::PH_CMD: begin
          if (sclk_rise) begin
            bit_cnt_q <= bit_cnt_q + 4'h1;
            if (bit_cnt_q == `SPI_LAST_CMD_BIT) begin
              phase_q <= line_irq_pkg::PH_DATA;
            end
          end
        end
        line_irq_pkg::PH_DATA: begin
          if (sclk_rise) begin
            // extra clocks after the data byte start another command byte; its first clock only wraps bit_cnt_q from 15 to 0
            if (bit_cnt_q == `SPI_LAST_DATA_BIT) begin
              phase_q <= line_irq_pkg::PH_IDLE;
            end else begin
              bit_cnt_q <= bit_cnt_q + 4'h1;
            end
          end
        end
        default: begin
          phase_q <= line_irq_pkg::PH_IDLE;
        end
      endcase
    end
  end

  // input shifter and command capture
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      shift_in_q <= 8'h00;
      cmd_q      <= 8'h00;
    end else if (sclk_rise && phase_q != line_irq_pkg::PH_IDLE) begin
      shift_in_q <= wr_data;
      if (phase_q == line_irq_pkg::PH_CMD && bit_cnt_q == `SPI_LAST_CMD_BIT) begin
        cmd_q <= wr_data;
      end
    end
  end

  // last data bit ends the access
  assign access_pulse = sclk_rise && phase_q == line_irq_pkg::PH_DATA
                        && bit_cnt_q == `SPI_LAST_DATA_BIT;
  assign wr_pulse     = access_pulse & ~is_read;

  // read data out, changes on falling edge so the master samples stable
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      spi_sdo_o   <= 1'b0;
      shift_out_q <= 8'h00;
    end else if (sclk_fall && phase_q == line_irq_pkg::PH_DATA) begin
      if (bit_cnt_q == 4'h8) begin
        // first data clock: snapshot the register
        spi_sdo_o   <= rd_data[7];
        shift_out_q <= {rd_data[6:0], 1'b0};
      end else begin
        spi_sdo_o   <= shift_out_q[7];
        shift_out_q <= {shift_out_q[6:0], 1'b0};
      end
    end
  end

  // drive sdo only during the data byte of a read
  assign spi_sdo_oe_o = sel & is_read & (phase_q == line_irq_pkg::PH_DATA);

  // ---------------------------------------------------------------
  // control_two register
  // ---------------------------------------------------------------
  logic [7:0] control_two_q;   // bit 5 held at zero
  logic       wr_control_two;  // write strobe for this register

  assign wr_control_two = wr_pulse && addr == `REG_CONTROL_TWO;

  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      control_two_q <= `CONTROL_TWO_RST;
    end else if (wr_control_two) begin
      control_two_q                     <= wr_data;
      control_two_q[`C2_RESERVED]       <= 1'b0;
      // watchdog enable can be set, never cleared by software
      control_two_q[`C2_WDOG_ON]        <= control_two_q[`C2_WDOG_ON] | wr_data[`C2_WDOG_ON];
    end
  end

  logic irq_pin_select;       // pin carries interrupt when high
  logic irq_polarity;         // active-high interrupt when set
  logic access_watchdog_on;   // watchdog running
  logic ring_irq_both_edges;  // ring flag on both burst edges

  assign irq_pin_select      = control_two_q[`C2_IRQ_PIN_SELECT];
  assign irq_polarity        = control_two_q[`C2_IRQ_POLARITY];
  assign access_watchdog_on  = control_two_q[`C2_WDOG_ON];
  assign ring_irq_both_edges = control_two_q[`C2_RING_BOTH_EDGES];

  // analog path controls straight from the register flops
  assign ext_loopback_on_o = control_two_q[`C2_EXT_LOOPBACK_ON];
  assign hybrid_connect_o  = control_two_q[`C2_HYBRID_CONNECT];
  assign rx_path_on_o      = control_two_q[`C2_RX_PATH_ON];

  // ---------------------------------------------------------------
  // interrupt_mask register
  // ---------------------------------------------------------------
  logic [7:0] interrupt_mask_q;  // one enable per source

  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      interrupt_mask_q <= `INTERRUPT_MASK_RST;
    end else if (wr_pulse && addr == `REG_INTERRUPT_MASK) begin
      interrupt_mask_q <= wr_data;
    end
  end

  // ---------------------------------------------------------------
  // interrupt source flags
  // ---------------------------------------------------------------
  logic [7:0] flag_clr;    // write of 0 clears, 1 leaves alone
  logic [7:0] irq_flags;   // sticky source flags
  logic [7:0] src_sig;     // one-bit sources by position
  logic [7:0] rise_en;     // edge selection per source
  logic [7:0] fall_en;

  assign flag_clr = (wr_pulse && addr == `REG_IRQ_FLAGS) ? ~wr_data : 8'h00;

  // one-bit sources; position 2 is the multi-bit loop current level
  always_comb begin
    src_sig                        = 8'h00;
    src_sig[`SRC_RING]             = ring_detect_i;
    src_sig[`SRC_RX_OVERLOAD]      = rx_overload_i;
    src_sig[`SRC_FRAME_LOSS]       = frame_lock_lost_i;
    src_sig[`SRC_BILLING_TONE]     = billing_tone_i;
    src_sig[`SRC_SUPPLY_DROPOUT]   = supply_dropout_i;
    src_sig[`SRC_TIP_GROUND]       = tip_ground_status_i;
    src_sig[`SRC_POLARITY_FLIP]    = line_voltage_msb_i;
  end

  // which edges raise each flag
  always_comb begin
    rise_en = 8'hFF;
    fall_en = 8'h00;
    // burst end flags only in two-interrupt mode; a flag still set from
    // the burst start just stays set, so an unserviced start yields one
    fall_en[`SRC_RING]          = ring_irq_both_edges;
    // a flip in either direction is a reversal
    fall_en[`SRC_POLARITY_FLIP] = 1'b1;
  end

  // one flag cell per one-bit source
  for (genvar i = 0; i < 8; i++) begin : g_src
    if (i != `SRC_LOOP_CURRENT_MAX) begin : g_one
      status_event_flag #(
        .W (1)
      ) u_flag (
        .clk_sys_i (clk_sys_i),
        .resetn_i  (resetn_i),
        .sig_i     (src_sig[i]),
        .rise_en_i (rise_en[i]),
        .fall_en_i (fall_en[i]),
        .clr_i     (flag_clr[i]),
        .flag_o    (irq_flags[i]),
        .level_o   ()
      );
    end
  end

  // loop current level reaching all ones
  status_event_flag #(
    .W (`LOOP_LEVEL_W)
  ) u_loop_max_flag (
    .clk_sys_i (clk_sys_i),
    .resetn_i  (resetn_i),
    .sig_i     (loop_current_level_i),
    .rise_en_i (rise_en[`SRC_LOOP_CURRENT_MAX]),
    .fall_en_i (fall_en[`SRC_LOOP_CURRENT_MAX]),
    .clr_i     (flag_clr[`SRC_LOOP_CURRENT_MAX]),
    .flag_o    (irq_flags[`SRC_LOOP_CURRENT_MAX]),
    .level_o   ()
  );

  // ---------------------------------------------------------------
  // access watchdog and hook control
  // ---------------------------------------------------------------
  logic [`WDOG_CNT_W-1:0] wdog_cnt_q;   // clocks since last access
  logic                   wdog_expire;  // window ran out, one cycle

  assign wdog_expire = access_watchdog_on && !access_pulse
                       && wdog_cnt_q == `WDOG_CNT_W'(WDOG_CYCLES - 1);

  // counter restarts on every access and after each expiry
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      wdog_cnt_q <= '0;
    end else if (!access_watchdog_on || access_pulse || wdog_expire) begin
      wdog_cnt_q <= '0;
    end else begin
      wdog_cnt_q <= wdog_cnt_q + `WDOG_CNT_W'(1);
    end
  end

  // off-hook bit; access and expiry never coincide, so order is moot
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      offhook_ctl_o <= `OFFHOOK_RST;
    end else if (wdog_expire) begin
      offhook_ctl_o <= 1'b0;
    end else if (wr_pulse && addr == `REG_HOOK_CONTROL) begin
      offhook_ctl_o <= wr_data[`HOOK_OFFHOOK_CTL];
    end
  end

  // ---------------------------------------------------------------
  // read mux; unmapped addresses read zero
  // ---------------------------------------------------------------
  always_comb begin
    case (addr)
      `REG_CONTROL_TWO:    rd_data = control_two_q;
      `REG_INTERRUPT_MASK: rd_data = interrupt_mask_q;
      `REG_IRQ_FLAGS:      rd_data = irq_flags;
      `REG_HOOK_CONTROL:   rd_data = {7'h00, offhook_ctl_o};
      default:             rd_data = 8'h00;
    endcase
  end

  // ---------------------------------------------------------------
  // shared output pin
  // ---------------------------------------------------------------
  logic irq_any;  // some unmasked flag is set

  // each mask bit gates its own flag
  assign irq_any = |(irq_flags & interrupt_mask_q);

  // registered so the pin never glitches while the mux switches
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      callprog_or_irq_pin_o <= 1'b0;
    end else if (irq_pin_select) begin
      // asserted level follows polarity, idle level is its inverse
      callprog_or_irq_pin_o <= irq_any ~^ irq_polarity;
    end else begin
      callprog_or_irq_pin_o <= callprog_i;
    end
  end

endmodule : line_interface_irq_control

// ==== verif/line_irq_props.sv ====
`timescale 1ns/10ps
// watches the shared pin, hook and path controls from the top ports only
module line_irq_props #(
  parameter int unsigned WDOG_CYCLES = 1000  // watchdog window in clocks
) (
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  input wire logic spi_cs_n_i,
  input wire logic spi_sdo_oe_o,
  input wire logic callprog_i,
  input wire logic callprog_or_irq_pin_o,
  input wire logic offhook_ctl_o,
  input wire logic ext_loopback_on_o,
  input wire logic hybrid_connect_o,
  input wire logic rx_path_on_o
);
  logic        frame_seen_q;  // a frame began since reset
  logic [31:0] idle_q;        // clocks with chip select high, saturation not needed here
  // helper state; cleared with the design so a mid-run reset starts afresh
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      frame_seen_q <= 1'b0;
      idle_q       <= 32'h0;
    end else begin
      frame_seen_q <= frame_seen_q | ~spi_cs_n_i;
      idle_q       <= spi_cs_n_i ? idle_q + 32'h1 : 32'h0;
    end
  end
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!resetn_i);

  pin_follow_a: assert property (
    $past(resetn_i) && !frame_seen_q |-> callprog_or_irq_pin_o == $past(callprog_i))
    else $error("shared pin not following the call-progress stream");
  loopback_hold_a: assert property (
    idle_q > 32'h8 |-> $stable(ext_loopback_on_o)) else $error("loopback moved without write");
  hybrid_hold_a: assert property (
    idle_q > 32'h8 |-> $stable(hybrid_connect_o)) else $error("hybrid moved without write");
  rx_hold_a: assert property (
    idle_q > 32'h8 |-> $stable(rx_path_on_o)) else $error("rx path moved without write");
  offhook_set_a: assert property (
    idle_q > 32'h8 |-> !$rose(offhook_ctl_o)) else $error("off-hook set without write");
  wdog_timeout_a: assert property (
    $fell(offhook_ctl_o) |-> idle_q > WDOG_CYCLES - 32) else $error("on-hook before window");
  sdo_release_a: assert property ( // serial port hand-back
    $rose(spi_cs_n_i) |-> ##[1:5] !spi_sdo_oe_o) else $error("sdo kept after deselect");
  sdo_quiet_a: assert property ( // no drive while deselected
    spi_cs_n_i [*6] |-> !spi_sdo_oe_o) else $error("sdo driven while deselected");

  timeout_c: cover property ($fell(offhook_ctl_o));
  read_c: cover property ($rose(spi_sdo_oe_o));
  loopback_c: cover property ($rose(ext_loopback_on_o));
endmodule : line_irq_props

bind line_interface_irq_control line_irq_props #(.WDOG_CYCLES(WDOG_CYCLES)) u_props (
  .clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .spi_cs_n_i(spi_cs_n_i),
  .spi_sdo_oe_o(spi_sdo_oe_o), .callprog_i(callprog_i),
  .callprog_or_irq_pin_o(callprog_or_irq_pin_o), .offhook_ctl_o(offhook_ctl_o),
  .ext_loopback_on_o(ext_loopback_on_o), .hybrid_connect_o(hybrid_connect_o),
  .rx_path_on_o(rx_path_on_o));

// ==== verif/line_irq_host.sv ====
`timescale 1ns/10ps
// host processor on the serial control port: mode 0, msb first
module line_irq_host #(
  parameter int HALF = 8  // sclk half period in clocks, kept above the 4-clock minimum
) (
  input  wire logic clk_sys_i,
  input  wire logic spi_sdo_i,
  output logic      spi_sclk_o,
  output logic      spi_cs_n_o,
  output logic      spi_sdi_o
);
  // idle: deselected, serial clock stands low
  initial begin
    spi_sclk_o = 1'b0;
    spi_cs_n_o = 1'b1;
    spi_sdi_o  = 1'b0;
  end
  // n clock edges, then the drive delay
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask : tick
  // one whole frame; read bits taken at each rise of the data byte
  task automatic xfer(input logic [7:0] cmd, input logic [7:0] wdat, output logic [7:0] rdat);
    logic [15:0] word;
    word = {cmd, wdat};
    rdat = 8'h00;
    tick(1);
    spi_cs_n_o = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      spi_sdi_o = word[i];
      tick(HALF);
      spi_sclk_o = 1'b1;
      if (i < 8) rdat = {rdat[6:0], spi_sdo_i};
      tick(HALF);
      spi_sclk_o = 1'b0;
    end
    tick(HALF);
    spi_cs_n_o = 1'b1;
    spi_sdi_o  = ~spi_sdi_o;  // released line shows no stale bit
    tick(HALF);              // keeps the deselect gap above 4 clocks
  endtask : xfer
endmodule : line_irq_host

// ==== verif/line_interface_irq_control_bench.sv ====
`timescale 1ns/10ps
// register-level checks of the line interface controls and interrupt pin
module line_interface_irq_control_bench;
  localparam int WDOG = 800;  // shortened window, longer than two frames
  logic       clk_sys;
  logic       resetn;
  logic       sclk, cs_n, sdi, sdo;
  logic [7:0] src;       // line-side statuses, one bit per source position
  logic       callprog;  // call-progress stream
  logic       pin, offhook, loopback, hybrid, rx;
  logic [7:0] rdat;
  int         miscompares;
  int         total_checks;

  always #2 clk_sys = ~clk_sys;
  // stream toggles every clock so a stale pin shows at once
  always @(posedge clk_sys) callprog <= #1 ~callprog;

  line_interface_irq_control #(.WDOG_CYCLES(WDOG)) DUT (
    .clk_sys_i(clk_sys), .resetn_i(resetn), .spi_sclk_i(sclk), .spi_cs_n_i(cs_n),
    .spi_sdi_i(sdi), .spi_sdo_o(sdo), .spi_sdo_oe_o(), .ring_detect_i(src[7]),
    .rx_overload_i(src[6]), .frame_lock_lost_i(src[5]), .billing_tone_i(src[4]),
    .supply_dropout_i(src[3]), .loop_current_level_i({5{src[2]}}),
    .tip_ground_status_i(src[1]), .line_voltage_msb_i(src[0]), .callprog_i(callprog),
    .callprog_or_irq_pin_o(pin), .offhook_ctl_o(offhook), .ext_loopback_on_o(loopback),
    .hybrid_connect_o(hybrid), .rx_path_on_o(rx));
  line_irq_host host (.clk_sys_i(clk_sys), .spi_sdo_i(sdo), .spi_sclk_o(sclk),
    .spi_cs_n_o(cs_n), .spi_sdi_o(sdi));

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: byte %h expected %h", $time, got, exp);
    end
  endtask : chk8
  task automatic chk1(input logic got, input logic exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: bit %b expected %b", $time, got, exp);
    end
  endtask : chk1
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    host.xfer({2'b00, a}, d, rdat);
  endtask : wr
  task automatic rd(input logic [5:0] a, input logic [7:0] exp);
    host.xfer({2'b10, a}, 8'h00, rdat);
    chk8(rdat, exp);
  endtask : rd
  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : wait_clk
  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : summarize

  // hang guard
  initial begin
    repeat (100000) @(posedge clk_sys);
    miscompares++;
    summarize();
  end

  initial begin
    clk_sys = 1'b0;
    callprog = 1'b0;
    src = 8'h00;
    resetn = 1'b0;
    miscompares = 0;
    total_checks = 0;
    wait_clk(12);
    resetn = 1'b1;
    wait_clk(20);
    rd(6'h02, 8'h00);
    rd(6'h3F, 8'h00);
    wr(6'h02, 8'h2B);
    rd(6'h02, 8'h0B);
    chk8({5'h00, loopback, hybrid, rx}, 8'h07);
    wr(6'h02, 8'h80);
    chk8({5'h00, loopback, hybrid, rx}, 8'h00);
    chk1(pin, 1'b1);
    // each source: flag sticks, mask gates the pin, clear releases it
    for (int i = 0; i < 8; i++) begin
      wr(6'h03, 8'h00);
      src[i] = 1'b1;
      wait_clk(20);
      src[i] = 1'b0;
      wait_clk(20);
      rd(6'h04, 8'h01 << i);
      chk1(pin, 1'b1);
      wr(6'h03, 8'h01 << i);
      chk1(pin, 1'b0);
      wr(6'h04, 8'h00);
      chk1(pin, 1'b1);
    end
    // polarity flip: the falling transition alone must raise the flag too
    src[0] = 1'b1;
    wait_clk(20);
    wr(6'h04, 8'h00);
    src[0] = 1'b0;
    wait_clk(20);
    rd(6'h04, 8'h01);
    wr(6'h04, 8'h00);
    // ring in two-edge mode, active-high pin
    wr(6'h02, 8'hC4);
    src[7] = 1'b1;
    wait_clk(20);
    chk1(pin, 1'b1);
    rd(6'h04, 8'h80);
    wr(6'h04, 8'h00);
    chk1(pin, 1'b0);
    src[7] = 1'b0;
    wait_clk(20);
    rd(6'h04, 8'h80);
    wr(6'h04, 8'h00);
    // ring in single-edge mode: no flag at burst end
    wr(6'h02, 8'hC0);
    src[7] = 1'b1;
    wait_clk(20);
    wr(6'h04, 8'h00);
    src[7] = 1'b0;
    wait_clk(20);
    rd(6'h04, 8'h00);
    // watchdog: sticky enable, restart by access, timeout on-hook
    wr(6'h05, 8'h01);
    chk1(offhook, 1'b1);
    wr(6'h02, 8'h10);
    wr(6'h02, 8'h00);
    rd(6'h02, 8'h10);
    for (int k = 0; k < 3; k++) begin
      wait_clk(200);
      rd(6'h03, 8'h80);
    end
    chk1(offhook, 1'b1);
    wait_clk(WDOG + 100);
    chk1(offhook, 1'b0);
    wr(6'h05, 8'h01);
    chk1(offhook, 1'b1);
    summarize();
  end
endmodule : line_interface_irq_control_bench
